// ---- verilog/cplc_pkg.sv ----
// Purpose : constants for the cpu priority level control block
// Assumes : 16-bit register port, byte offsets on word boundaries
// Notes   : offsets are word aligned, data sits in the low 16 bits
// ==========================================================================
// package
package cplc_pkg;
  localparam int unsigned CPLC_AW = 8;
  localparam int unsigned CPLC_DW = 16;

  // ========================================================================
  // register offsets
  localparam logic [7:0] CPLC_OFS_STATUS  = 8'h00;
  localparam logic [7:0] CPLC_OFS_CORE    = 8'h04;
  localparam logic [7:0] CPLC_OFS_ICON1   = 8'h08;
  localparam logic [7:0] CPLC_OFS_EVT_ST  = 8'h0c;
  localparam logic [7:0] CPLC_OFS_EVT_CLR = 8'h10;
  localparam logic [7:0] CPLC_OFS_EVT_EN  = 8'h14;

  // ========================================================================
  // field positions
  localparam int unsigned CPLC_LOW_LSB   = 5;
  localparam int unsigned CPLC_LOW_MSB   = 7;
  localparam int unsigned CPLC_TOP_POS   = 3;
  localparam int unsigned CPLC_NEST_POS  = 15;
  localparam int unsigned CPLC_OSC_POS   = 1;
  localparam logic [15:0] CPLC_ICON1_MASK = 16'hffde;
  localparam logic [2:0]  CPLC_LOW_ALL_MASKED = 3'h7;

  // ========================================================================
  // event bits
  localparam int unsigned CPLC_EVT_N      = 3;
  localparam int unsigned CPLC_EVT_OSC    = 0;
  localparam int unsigned CPLC_EVT_ACCEPT = 1;
  localparam int unsigned CPLC_EVT_FROZEN = 2;

  // ========================================================================
  // reset values
  localparam logic [2:0]  CPLC_RST_LOW   = 3'h0;
  localparam logic        CPLC_RST_TOP   = 1'b0;
  localparam logic [15:0] CPLC_RST_ICON1 = 16'h0000;
  localparam logic [2:0]  CPLC_RST_EVT   = 3'h0;
  localparam logic [15:0] CPLC_RST_DATA  = 16'h0000;
endpackage : cplc_pkg

// ---- verilog/cplc_top.sv ----
// Purpose : cpu interrupt priority level state, masking and acceptance
// Assumes : sequencer and request sources run on i_clk_sys
// Notes   : sequencer level loads take precedence over software writes
// Functional notes
// - low level bits at status bits 7..5
// - software write changes low level bits
// - top level bit is read-only to software
// - level is top bit above low bits
// - binary levels 0..7, plus eight with top
// - low bits 111 block all user interrupts
// - top bit set blocks all user interrupts
// - nesting disable freezes low bits against writes
// - top bit shows level above seven
// - control one holds nesting and trap flags
// - oscillator failure sets its trap flag
`timescale 1ns/1ns
module cplc_top
  import cplc_pkg::*;
(
  input  wire logic         i_clk_sys,
  input  wire logic         i_reset_n,
  input  wire logic [7:0]   i_addr,
  input  wire logic [15:0]  i_wdata,
  input  wire logic         i_wr,
  input  wire logic         i_rd,
  output logic      [15:0]  o_rdata,
  input  wire logic         i_seq_load,
  input  wire logic [3:0]   i_seq_level,
  input  wire logic         i_osc_fail,
  input  wire logic         i_req_valid,
  input  wire logic [2:0]   i_req_prio,
  output logic              o_req_accept,
  output logic      [3:0]   o_cpu_level,
  output logic              o_irq
);

  // ========================================================================
  // state
  typedef struct packed {
    logic [2:0]  low_bits;
    logic        top_bit;
    logic [15:0] icon1;
    logic [2:0]  evt_stat;
    logic [2:0]  evt_en;
    logic [15:0] rdata;
    logic        irq;
    logic        accept;
    logic [3:0]  level;
  } cplc_state_t;

  cplc_state_t st_reg;
  cplc_state_t st_next;

  // level formed by stacking the top bit over the low bits
  function automatic logic [3:0] cplc_level(input logic top, input logic [2:0] low);
    cplc_level = {top, low};
  endfunction : cplc_level

  // strict compare; a top bit of one lifts the level past every user prio
  function automatic logic cplc_may_accept(input logic [3:0] lvl, input logic [2:0] prio);
    cplc_may_accept = ({1'b0, prio} > lvl);
  endfunction : cplc_may_accept

  // ========================================================================
  // decode
  logic wr_status;
  logic wr_core;
  logic wr_icon1;
  logic wr_evt_clr;
  logic wr_evt_en;
  logic nest_dis;
  logic frozen_try;
  logic accept_now;
  logic [2:0] evt_set;

  // strobes per register, unmapped addresses ignore writes
  always_comb
  begin
    wr_status  = i_wr && (i_addr == CPLC_OFS_STATUS);
    wr_core    = i_wr && (i_addr == CPLC_OFS_CORE);
    wr_icon1   = i_wr && (i_addr == CPLC_OFS_ICON1);
    wr_evt_clr = i_wr && (i_addr == CPLC_OFS_EVT_CLR);
    wr_evt_en  = i_wr && (i_addr == CPLC_OFS_EVT_EN);
    nest_dis   = st_reg.icon1[CPLC_NEST_POS];
    frozen_try = wr_status && nest_dis && !i_seq_load;
    accept_now = i_req_valid && (st_reg.low_bits != CPLC_LOW_ALL_MASKED)
                 && cplc_may_accept(st_reg.level, i_req_prio);
    evt_set    = '0;
    evt_set[CPLC_EVT_OSC]    = i_osc_fail;
    evt_set[CPLC_EVT_ACCEPT] = accept_now;
    evt_set[CPLC_EVT_FROZEN] = frozen_try;
  end

  // ========================================================================
  // next state
  always_comb
  begin
    st_next = st_reg;
    // sequencer owns the level on entry and return of an exception
    if (i_seq_load)
    begin
      st_next.low_bits = i_seq_level[2:0];
      st_next.top_bit  = i_seq_level[3];
    end
    else if (wr_status && !nest_dis)
    begin
      st_next.low_bits = i_wdata[CPLC_LOW_MSB:CPLC_LOW_LSB];
    end
    // writes to the core word never touch the top bit
    if (wr_core)
    begin
      st_next.top_bit = st_next.top_bit;
    end
    // control one: nesting disable plus trap flags, holes read zero
    if (wr_icon1)
    begin
      st_next.icon1 = i_wdata & CPLC_ICON1_MASK;
    end
    // a failure in the same cycle as a write still leaves the flag set
    if (i_osc_fail)
    begin
      st_next.icon1[CPLC_OSC_POS] = 1'b1;
    end
    // events are sticky; a set beats a clear arriving together
    if (wr_evt_clr)
    begin
      st_next.evt_stat = st_reg.evt_stat & ~i_wdata[CPLC_EVT_N-1:0];
    end
    st_next.evt_stat = st_next.evt_stat | evt_set;
    if (wr_evt_en)
    begin
      st_next.evt_en = i_wdata[CPLC_EVT_N-1:0];
    end
    // read data valid only in the cycle after the strobe
    st_next.rdata = CPLC_RST_DATA;
    if (i_rd)
    begin
      case (i_addr)
        CPLC_OFS_STATUS:
        begin
          st_next.rdata[CPLC_LOW_MSB:CPLC_LOW_LSB] = st_reg.low_bits;
        end
        CPLC_OFS_CORE:
        begin
          st_next.rdata[CPLC_TOP_POS] = st_reg.top_bit;
        end
        CPLC_OFS_ICON1:
        begin
          st_next.rdata = st_reg.icon1;
        end
        CPLC_OFS_EVT_ST:
        begin
          st_next.rdata[CPLC_EVT_N-1:0] = st_reg.evt_stat;
        end
        CPLC_OFS_EVT_EN:
        begin
          st_next.rdata[CPLC_EVT_N-1:0] = st_reg.evt_en;
        end
        default:
        begin
          st_next.rdata = CPLC_RST_DATA;
        end
      endcase
    end
    st_next.accept = accept_now;
    st_next.level  = cplc_level(st_next.top_bit, st_next.low_bits);
    st_next.irq    = |(st_next.evt_stat & st_next.evt_en);
  end

  // ========================================================================
  // registers
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      st_reg.low_bits <= CPLC_RST_LOW;
      st_reg.top_bit  <= CPLC_RST_TOP;
      st_reg.icon1    <= CPLC_RST_ICON1;
      st_reg.evt_stat <= CPLC_RST_EVT;
      st_reg.evt_en   <= CPLC_RST_EVT;
      st_reg.rdata    <= CPLC_RST_DATA;
      st_reg.irq      <= 1'b0;
      st_reg.accept   <= 1'b0;
      st_reg.level    <= 4'h0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state flops
  assign o_rdata      = st_reg.rdata;
  assign o_req_accept = st_reg.accept;
  assign o_cpu_level  = st_reg.level;
  assign o_irq        = st_reg.irq;

  // ========================================================================
  // checks
  chk_low_write_takes: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (wr_status && !nest_dis && !i_seq_load) |=> (st_reg.low_bits == $past(i_wdata[7:5])))
    else $error("low level bits missed a software write");

  chk_nest_freeze_low: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (wr_status && nest_dis && !i_seq_load) |=> $stable(st_reg.low_bits))
    else $error("low level bits changed while frozen");

  chk_top_readonly: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_wr && !i_seq_load) |=> $stable(st_reg.top_bit))
    else $error("software changed the top level bit");

  chk_level_concat: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    o_cpu_level == {st_reg.top_bit, st_reg.low_bits})
    else $error("cpu level does not match its bits");

  chk_top_blocks_user: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (st_reg.top_bit && i_req_valid) |=> !o_req_accept)
    else $error("user request accepted above level seven");

  chk_all_masked: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (st_reg.low_bits == 3'h7) |=> !o_req_accept)
    else $error("user request accepted at masked level");

  chk_accept_cause: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    o_req_accept |-> ($past(i_req_valid) && ({1'b0, $past(i_req_prio)} > $past(o_cpu_level))))
    else $error("accept without a higher priority request");

  chk_accept_given: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_req_valid && !st_reg.top_bit && (st_reg.low_bits != 3'h7)
     && (i_req_prio > st_reg.low_bits)) |=> o_req_accept)
    else $error("eligible request was not accepted");

  chk_osc_flag_set: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    i_osc_fail |=> (st_reg.icon1[1] && st_reg.evt_stat[0]) [*1])
    else $error("oscillator failure flag not set");

  chk_status_read: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_rd && (i_addr == CPLC_OFS_STATUS)) |=> (o_rdata[7:5] == $past(st_reg.low_bits)))
    else $error("status read shows wrong level bits");

  chk_core_read: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_rd && (i_addr == CPLC_OFS_CORE)) |=> (o_rdata[3] == $past(o_cpu_level[3])))
    else $error("core read shows wrong top bit");

  chk_irq_follows: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    o_irq == |(st_reg.evt_stat & st_reg.evt_en))
    else $error("interrupt output disagrees with status");

  // ========================================================================
  // level ownership checks
  // a sequencer load lands whole, even when software writes in the same cycle
  chk_seq_load_level: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    i_seq_load |=> (o_cpu_level == $past(i_seq_level)))
    else $error("sequencer load did not reach the cpu level");

  chk_seq_beats_write: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_seq_load && wr_status) |=> (st_reg.low_bits == $past(i_seq_level[2:0])))
    else $error("software write beat a sequencer load");

  chk_level_hold: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (!i_seq_load && !wr_status) |=> $stable(o_cpu_level))
    else $error("cpu level moved without a load or write");

  chk_core_write_kept: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (wr_core && !i_seq_load) |=> $stable(o_cpu_level))
    else $error("core word write changed the cpu level");

  chk_frozen_event: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    frozen_try |=> st_reg.evt_stat[CPLC_EVT_FROZEN])
    else $error("refused status write left no event");

  // ========================================================================
  // acceptance checks
  // both sides of the strict compare are watched, not only the accept side
  chk_low_prio_refused: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_req_valid && ({1'b0, i_req_prio} <= o_cpu_level)) |=> !o_req_accept)
    else $error("request at or below the level was accepted");

  chk_no_req_no_accept: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    !i_req_valid |=> !o_req_accept)
    else $error("accept without any pending request");

  // ========================================================================
  // control one and event checks
  chk_icon1_holes: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (st_reg.icon1 & ~CPLC_ICON1_MASK) == 16'h0000)
    else $error("unimplemented control one bit is set");

  chk_icon1_write: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (wr_icon1 && !i_osc_fail) |=> (st_reg.icon1 == ($past(i_wdata) & CPLC_ICON1_MASK)))
    else $error("control one write did not land");

  chk_osc_sticky: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (st_reg.icon1[CPLC_OSC_POS] && !wr_icon1) |=> st_reg.icon1[CPLC_OSC_POS])
    else $error("oscillator failure flag dropped by itself");

  chk_clear_lands: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (wr_evt_clr && i_wdata[CPLC_EVT_OSC] && !i_osc_fail) |=> !st_reg.evt_stat[CPLC_EVT_OSC])
    else $error("event clear did not clear the failure event");

  chk_enable_write: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    wr_evt_en |=> (st_reg.evt_en == $past(i_wdata[CPLC_EVT_N-1:0])))
    else $error("event enable write did not land");

  chk_rdata_idle: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    !i_rd |=> (o_rdata == CPLC_RST_DATA))
    else $error("read data stood without a read strobe");

  // ========================================================================
  // reset checks
  // no disable here since the check must look inside reset; asking for two
  // low samples skips the start-up race between the first edge and reset
  chk_reset_clears: assert property (@(posedge i_clk_sys)
    (!i_reset_n ##1 !i_reset_n) |-> ((o_cpu_level == 4'h0) && !nest_dis && !o_irq))
    else $error("reset left the level or nesting disable set");

endmodule : cplc_top

// ---- testbench/cplc_seq_model.sv ----
// Purpose : model of the exception sequencer and user request sources
// Assumes : shares i_clk_sys with the block, no synchroniser needed
// Notes   : idle lines show the inverse of the last value, never stale data
`timescale 1ns/1ns
module cplc_seq_model
(
  input  wire logic       i_clk_sys,
  output logic            o_seq_load,
  output logic [3:0]      o_seq_level,
  output logic            o_osc_fail,
  output logic            o_req_valid,
  output logic [2:0]      o_req_prio
);
  // ==========================================================================
  // idle at time zero
  initial
  begin
    o_seq_load  = 1'b0;
    o_seq_level = 4'h0;
    o_osc_fail  = 1'b0;
    o_req_valid = 1'b0;
    o_req_prio  = 3'h0;
  end

  // one-cycle event: 0 loads a level, 1 fails the oscillator, 2 raises a request
  task automatic pulse(input int kind, input logic [3:0] v);
  begin
    @(posedge i_clk_sys);
    o_seq_load  <= (kind == 0);
    o_osc_fail  <= (kind == 1);
    o_req_valid <= (kind == 2);
    o_seq_level <= v;
    o_req_prio  <= v[2:0];
    @(posedge i_clk_sys);
    o_seq_load  <= 1'b0;
    o_osc_fail  <= 1'b0;
    o_req_valid <= 1'b0;
    o_seq_level <= ~v;
    o_req_prio  <= ~v[2:0];
    #1;
  end
  endtask : pulse
endmodule : cplc_seq_model

// ---- testbench/tb_top.sv ----
// Purpose : self-checking bench for the priority level block
// Assumes : one read data cycle, writes land at the sampling edge
// Notes   : the bench keeps its own level and predicts every acceptance
`timescale 1ns/1ns
module tb_top;
  import cplc_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        wr;
  logic        rd;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        ld;
  logic [3:0]  ld_lvl;
  logic        osc;
  logic        rv;
  logic [2:0]  rp;
  logic        acc;
  logic [3:0]  lvl_o;
  logic        irq;
  logic [31:0] seed;
  int          lvl;
  int          error_cnt;
  int          total_checks;

  cplc_top dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_seq_load(ld), .i_seq_level(ld_lvl),
    .i_osc_fail(osc), .i_req_valid(rv), .i_req_prio(rp), .o_req_accept(acc),
    .o_cpu_level(lvl_o), .o_irq(irq));
  cplc_seq_model seq (.i_clk_sys(clk), .o_seq_load(ld), .o_seq_level(ld_lvl),
    .o_osc_fail(osc), .o_req_valid(rv), .o_req_prio(rp));

  // ==========================================================================
  // clock and helpers
  always #50 clk = ~clk;

  function automatic logic [31:0] rnd();
  begin
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  end
  endfunction : rnd

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
  begin
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  end
  endtask : chk

  // one-cycle strobes, nothing released before the sampling edge
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
  begin
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    wdata <= ~d;
    #1;
  end
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
  begin
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk(rdata, exp);
  end
  endtask : rd_chk

  // model of acceptance: top bit clear, low bits not 111, priority above level
  task automatic req_chk(input logic [2:0] p);
  begin
    seq.pulse(2, {1'b0, p});
    chk({15'h0, acc}, {15'h0, (lvl < 8) && (lvl != 7) && (int'(p) > lvl)});
  end
  endtask : req_chk

  task automatic finish_test();
  begin
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask : finish_test

  // ==========================================================================
  // watchdog, generous against about five hundred cycles of tests
  initial
  begin
    #1000000;
    error_cnt++;
    finish_test();
  end

  // ==========================================================================
  // main sequence
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    seed = 32'hb5fc;
    lvl = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    chk({12'h0, lvl_o}, 16'h0000);
    rd_chk(CPLC_OFS_ICON1, 16'h0000);
    $display("test reset done");
    // every level loaded by the sequencer, requests of every priority
    for (int k = 0; k < 16; k++)
    begin
      seq.pulse(0, k[3:0]);
      lvl = k;
      chk({12'h0, lvl_o}, 16'(k));
      rd_chk(CPLC_OFS_CORE, {12'h0, k[3], 3'h0});
      rd_chk(CPLC_OFS_STATUS, {8'h0, k[2:0], 5'h0});
      for (int p = 0; p < 8; p++)
        req_chk(p[2:0]);
    end
    $display("test sequencer levels done");
    // software writes with a random upper byte and ones in bits 4..0 of the status word
    // the top bit left by the last load is read-only, so the sequencer drops it
    seq.pulse(0, 4'h0);
    lvl = 0;
    for (int i = 7; i >= 0; i--)
    begin
      wr_reg(CPLC_OFS_STATUS, {8'(rnd() >> 8), i[2:0], 5'h1f});
      lvl = i;
      chk({12'h0, lvl_o}, 16'(i));
      rd_chk(CPLC_OFS_STATUS, {8'h0, i[2:0], 5'h0});
      req_chk(3'(rnd()));
    end
    wr_reg(CPLC_OFS_CORE, 16'hffff);
    chk({12'h0, lvl_o}, 16'h0000);
    // a top bit set by the sequencer survives core and status writes
    seq.pulse(0, 4'h9);
    wr_reg(CPLC_OFS_CORE, 16'h0000);
    chk({12'h0, lvl_o}, 16'h0009);
    wr_reg(CPLC_OFS_STATUS, 16'h0040);
    chk({12'h0, lvl_o}, 16'h000a);
    lvl = 10;
    req_chk(3'h7);
    // a sequencer load in the same cycle as a status write wins
    fork
      wr_reg(CPLC_OFS_STATUS, 16'h00e0);
      seq.pulse(0, 4'h2);
    join
    chk({12'h0, lvl_o}, 16'h0002);
    lvl = 2;
    $display("test software writes done");
    // frozen low bits while nesting is disabled
    wr_reg(CPLC_OFS_EVT_CLR, 16'h0007);
    wr_reg(CPLC_OFS_ICON1, 16'h8000);
    rd_chk(CPLC_OFS_ICON1, 16'h8000);
    wr_reg(CPLC_OFS_STATUS, 16'h00a0);
    chk({12'h0, lvl_o}, 16'h0002);
    rd_chk(CPLC_OFS_EVT_ST, 16'h0004);
    wr_reg(CPLC_OFS_ICON1, 16'h0000);
    wr_reg(CPLC_OFS_STATUS, 16'h00a0);
    chk({12'h0, lvl_o}, 16'h0005);
    $display("test nesting freeze done");
    // oscillator failure raises, masks and clears the interrupt
    wr_reg(CPLC_OFS_EVT_CLR, 16'h0007);
    wr_reg(CPLC_OFS_EVT_EN, 16'h0001);
    chk({15'h0, irq}, 16'h0000);
    seq.pulse(1, 4'h0);
    chk({15'h0, irq}, 16'h0001);
    rd_chk(CPLC_OFS_ICON1, 16'h0002);
    rd_chk(CPLC_OFS_EVT_ST, 16'h0001);
    wr_reg(CPLC_OFS_EVT_EN, 16'h0000);
    chk({15'h0, irq}, 16'h0000);
    wr_reg(CPLC_OFS_EVT_CLR, 16'h0001);
    rd_chk(CPLC_OFS_EVT_ST, 16'h0000);
    // a failure in the cycle of a clear or a control one write still sets
    fork
      wr_reg(CPLC_OFS_EVT_CLR, 16'h0001);
      seq.pulse(1, 4'h0);
    join
    rd_chk(CPLC_OFS_EVT_ST, 16'h0001);
    fork
      wr_reg(CPLC_OFS_ICON1, 16'h0000);
      seq.pulse(1, 4'h0);
    join
    rd_chk(CPLC_OFS_ICON1, 16'h0002);
    wr_reg(CPLC_OFS_ICON1, 16'h0000);
    rd_chk(CPLC_OFS_ICON1, 16'h0000);
    rd_chk(8'h40, 16'h0000);
    $display("test oscillator failure done");
    // reset in mid-run with nesting disabled and a raised level
    wr_reg(CPLC_OFS_ICON1, 16'h8000);
    seq.pulse(0, 4'hb);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    lvl = 0;
    chk({12'h0, lvl_o}, 16'h0000);
    rd_chk(CPLC_OFS_ICON1, 16'h0000);
    wr_reg(CPLC_OFS_STATUS, 16'h0040);
    chk({12'h0, lvl_o}, 16'h0002);
    $display("test mid-run reset done");
    finish_test();
  end
endmodule : tb_top
